// *** pmwc_device.sv ***
// Purpose: Power state, transceiver reset and wake output control of the device.
// Assumes: Wake event inputs are asynchronous levels; softRst is on core_clk.
// Notes: rstn is the power-on reset, softRst the software device reset.
// Functional notes
// - Power state field encodes three states.
// - Byte test write wakes device from sleep.
// - Host writes only wake register while unready.
// - Transceiver reset held 100 us, then self-clears.
// - Transceiver reset writes ignored while bit high.
// - Wake frame event drives enabled wake output.
// - Enabled wake frame event raises wake interrupt.
// - Energy event drives output and interrupt.
// - Drive type selects open-drain or push-pull.
// - Wake cause field reports event source.
// - Cause cleared by one, only when ready.
// - Cause clears only after source clears.
// - Pulse mode 50 ms, else held level.
// - Output drops on cause or enable clear.
// - Push-pull polarity follows polarity bit.
// - Output enable gates pin, not interrupt.
// - Ready bit shows device stable.
// - Unready host reads only two registers.
// - Writes need a read first after wake.
// - Control register readable in every state.
`timescale 1ns/10ps
`include "pmwc_regs.svh"

module pmwc_device #(
   parameter int PULSE_CYC = `PMWC_PULSE_MS * 1000 * `PMWC_CLK_MHZ,
   parameter logic [31:0] HWCFG_VAL = 32'h0000_0000
) (
   input wire logic core_clk, // Core clock.
   input wire logic rstn, // Power-on reset, synchronous.
   input wire logic ce, // Clock enable.
   input wire logic softRst, // Software device reset.
   pmwc_if.dev bus, // Register link.
   input wire logic wolEvent, // Wake frame or magic packet seen.
   input wire logic energyEvent, // Line energy seen.
   output logic phyReset, // Transceiver reset, high active.
   output logic [1:0] powerState, // Current power state.
   output logic deviceReady, // Device ready.
   output logic wakePinO, // Wake pin level.
   output logic wakePinOe, // Wake pin driven.
   output logic wakeIrq // Wake interrupt.
);
   import pmwc_pkg::*;

   localparam int PHY_CYC = `PMWC_PHYRST_US * `PMWC_CLK_MHZ;
   localparam pmwc_dev_t DEV_RST = '{st: PMWC_WAKE, default: '0};

   if (PULSE_CYC < 1) begin : g_bad_pulse
      $error("PULSE_CYC must be at least one");
   end

   pmwc_dev_t q;
   pmwc_dev_t d;

   // ------------------------------------------------------------------
   // Read view of the power management control register
   // ------------------------------------------------------------------
   function automatic logic [31:0] pmtWord(input pmwc_dev_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`PMWC_MODE_LSB +: 2] = s.mode;
      w[`PMWC_PHYRST_BIT] = s.phyRst;
      w[`PMWC_WOLEN_BIT] = s.wolEn;
      w[`PMWC_EDEN_BIT] = s.edEn;
      w[`PMWC_TYPE_BIT] = s.drvType;
      w[`PMWC_CAUSE_LSB +: 2] = s.cause;
      w[`PMWC_PULSE_BIT] = s.pulseSel;
      w[`PMWC_POL_BIT] = s.pol;
      w[`PMWC_OEN_BIT] = s.outEn;
      w[`PMWC_READY_BIT] = s.ready;
      return w;
   endfunction : pmtWord

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic acc;
      logic wrOk;
      logic [31:0] wd;
      logic wolRise;
      logic edRise;
      logic [1:0] clr;
      logic [1:0] live;
      logic trig;
      acc = 1'b0;
      wrOk = 1'b0;
      wd = bus.wdata;
      wolRise = 1'b0;
      edRise = 1'b0;
      clr = 2'h0;
      live = 2'h0;
      trig = 1'b0;
      d = q;
      if (softRst) begin
         d = DEV_RST;
         d.drvType = q.drvType;
         d.pol = q.pol;
      end else begin
         d.wolS1 = wolEvent;
         d.wolS2 = q.wolS1;
         d.wolS3 = q.wolS2;
         d.edS1 = energyEvent;
         d.edS2 = q.edS1;
         d.edS3 = q.edS2;
         wolRise = q.wolS2 & ~q.wolS3 & q.wolEn;
         edRise = q.edS2 & ~q.edS3 & q.edEn;

         // Ready comes a fixed time after reset or wake.
         case (q.st)
            PMWC_WAKE: begin
               d.readyCnt = q.readyCnt + 8'h01;
               if (q.readyCnt == 8'(`PMWC_READY_CYC - 1)) begin
                  d.st = PMWC_RUN;
                  d.ready = 1'b1;
                  d.readyCnt = 8'h00;
               end
            end
            PMWC_SLEEP: begin
               d.ready = 1'b0;
            end
            default: begin
            end
         endcase

         // Register link: one access per request, acked next cycle.
         acc = bus.req & ~q.ack;
         d.ack = acc;
         wrOk = q.ready & q.readSeen;
         if (acc && !bus.we) begin
            d.readSeen = 1'b1;
            if (bus.addr == `PMWC_PMT_OFS) begin
               d.rdata = pmtWord(q);
            end else if (bus.addr == `PMWC_HWCFG_OFS) begin
               d.rdata = HWCFG_VAL;
            end else begin
               d.rdata = 32'h0000_0000;
            end
         end
         if (acc && bus.we && bus.addr == `PMWC_BYTE_TEST_OFS && q.st == PMWC_SLEEP) begin
            d.st = PMWC_WAKE;
            d.mode = `PMWC_MODE_D0;
            d.readSeen = 1'b0;
         end else if (acc && bus.we && wrOk && bus.addr == `PMWC_PMT_OFS) begin
            d.wolEn = wd[`PMWC_WOLEN_BIT];
            d.edEn = wd[`PMWC_EDEN_BIT];
            d.drvType = wd[`PMWC_TYPE_BIT];
            d.pulseSel = wd[`PMWC_PULSE_BIT];
            d.pol = wd[`PMWC_POL_BIT];
            d.outEn = wd[`PMWC_OEN_BIT];
            if (wd[`PMWC_PHYRST_BIT] && !q.phyRst) begin
               d.phyRst = 1'b1;
               d.phyCnt = 12'(PHY_CYC);
            end
            clr = wd[`PMWC_CAUSE_LSB +: 2];
            if (wd[`PMWC_MODE_LSB +: 2] == `PMWC_MODE_D1 ||
                wd[`PMWC_MODE_LSB +: 2] == `PMWC_MODE_D2) begin
               d.mode = wd[`PMWC_MODE_LSB +: 2];
               d.st = PMWC_SLEEP;
               d.ready = 1'b0;
            end
         end

         // Transceiver reset timing.
         if (q.phyRst) begin
            d.phyCnt = q.phyCnt - 12'h001;
            if (q.phyCnt == 12'h001) begin
               d.phyRst = 1'b0;
            end
         end

         // Wake cause: the clear needs the source gone; a new event wins.
         if (clr[0] && !q.edS2) begin
            d.cause[0] = 1'b0;
         end
         if (clr[1] && !q.wolS2) begin
            d.cause[1] = 1'b0;
         end
         if (edRise) begin
            d.cause[0] = 1'b1;
         end
         if (wolRise) begin
            d.cause[1] = 1'b1;
         end
         live = d.cause & {d.wolEn, d.edEn};
         d.irq = |live;

         // Wake output activity.
         trig = (wolRise | edRise) & d.outEn;
         if (trig) begin
            d.actv = 1'b1;
            d.pulseCnt = 32'(PULSE_CYC);
         end else if (q.actv && q.pulseSel) begin
            d.pulseCnt = q.pulseCnt - 32'h0000_0001;
            if (q.pulseCnt <= 32'h0000_0001) begin
               d.actv = 1'b0;
            end
         end
         if (live == 2'h0 || !d.outEn) begin
            d.actv = 1'b0;
         end

         // Pin drive.
         if (d.drvType) begin
            d.pinOe = 1'b1;
            d.pinO = d.pol ? d.actv : ~d.actv;
         end else begin
            d.pinOe = d.actv;
            d.pinO = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= DEV_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign bus.ack = q.ack;
   assign bus.rdata = q.rdata;
   assign phyReset = q.phyRst;
   assign powerState = q.mode;
   assign deviceReady = q.ready;
   assign wakePinO = q.pinO;
   assign wakePinOe = q.pinOe;
   assign wakeIrq = q.irq;

endmodule : pmwc_device

// *** pmwc_host.sv ***
// Purpose: Host controller that issues device register accesses ordered over APB.
// Assumes: APB slave on core_clk; device link on the same clock.
// Notes: Refuses accesses the device cannot take while it is not ready.
`timescale 1ns/10ps
`include "pmwc_regs.svh"

module pmwc_host (
   input wire logic core_clk, // Core clock.
   input wire logic rstn, // Reset, synchronous.
   input wire logic ce, // Clock enable.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic pready, // APB ready.
   output logic [31:0] prdata, // APB read data.
   output logic pslverr, // APB error.
   pmwc_if.host bus // Register link.
);
   import pmwc_pkg::*;

   localparam pmwc_host_s_t HOST_RST = '{st: PMWC_H_IDLE, needRead: 1'b1, default: '0};

   pmwc_host_s_t q;
   pmwc_host_s_t d;

   // Accesses allowed for the known ready state.
   function automatic logic allowed(input logic [7:0] a, input logic we, input logic rdy);
      if (rdy) begin
         return 1'b1;
      end else if (we) begin
         return a == `PMWC_BYTE_TEST_OFS;
      end else begin
         return a == `PMWC_PMT_OFS || a == `PMWC_HWCFG_OFS;
      end
   endfunction : allowed

   function automatic logic [31:0] statWord(input pmwc_host_s_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`PMWC_H_BUSY_BIT] = s.st != PMWC_H_IDLE;
      w[`PMWC_H_REFUSED_BIT] = s.refused;
      w[`PMWC_H_RDY_BIT] = s.rdyShadow;
      w[`PMWC_H_NEEDRD_BIT] = s.needRead;
      return w;
   endfunction : statWord

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic setup;
      logic wrAcc;
      logic rdy;
      setup = psel & ~penable;
      wrAcc = psel & penable & q.pready & pwrite;
      rdy = q.rdyShadow;
      d = q;
      d.pready = setup;
      if (setup) begin
         d.pslverr = 1'b0;
         if (paddr == `PMWC_H_CMD_OFS) begin
            d.prdata = {23'h0, q.cmdWe, q.cmdAddr};
         end else if (paddr == `PMWC_H_WDATA_OFS) begin
            d.prdata = q.cmdWdata;
         end else if (paddr == `PMWC_H_STAT_OFS) begin
            d.prdata = statWord(q);
         end else if (paddr == `PMWC_H_RDATA_OFS) begin
            d.prdata = q.rdata;
         end else begin
            d.prdata = 32'h0000_0000;
            d.pslverr = 1'b1;
         end
      end
      if (wrAcc && paddr == `PMWC_H_WDATA_OFS) begin
         d.cmdWdata = pwdata;
      end
      if (wrAcc && paddr == `PMWC_H_CMD_OFS) begin
         d.cmdAddr = pwdata[7:0];
         d.cmdWe = pwdata[`PMWC_H_WE_BIT];
         if (q.st != PMWC_H_IDLE || !allowed(pwdata[7:0], pwdata[`PMWC_H_WE_BIT], rdy)) begin
            d.refused = 1'b1;
            d.cmdAddr = q.cmdAddr;
            d.cmdWe = q.cmdWe;
         end else if (pwdata[`PMWC_H_WE_BIT] && q.needRead) begin
            d.refused = 1'b0;
            d.st = PMWC_H_PRE;
            d.req = 1'b1;
            d.we = 1'b0;
            d.addr = `PMWC_PMT_OFS;
         end else begin
            d.refused = 1'b0;
            d.st = PMWC_H_XFER;
            d.req = 1'b1;
            d.we = pwdata[`PMWC_H_WE_BIT];
            d.addr = pwdata[7:0];
            d.wdata = q.cmdWdata;
         end
      end
      case (q.st)
         PMWC_H_PRE: begin
            if (bus.ack) begin
               d.needRead = 1'b0;
               d.rdyShadow = bus.rdata[`PMWC_READY_BIT];
               d.req = 1'b0;
               d.st = PMWC_H_IDLE;
               if (allowed(q.cmdAddr, q.cmdWe, bus.rdata[`PMWC_READY_BIT])) begin
                  d.req = 1'b1;
                  d.st = PMWC_H_XFER;
                  d.we = q.cmdWe;
                  d.addr = q.cmdAddr;
                  d.wdata = q.cmdWdata;
               end else begin
                  d.refused = 1'b1;
               end
            end
         end
         PMWC_H_XFER: begin
            if (bus.ack) begin
               d.req = 1'b0;
               d.st = PMWC_H_IDLE;
               if (!q.we) begin
                  d.rdata = bus.rdata;
                  d.needRead = 1'b0;
                  if (q.addr == `PMWC_PMT_OFS) begin
                     d.rdyShadow = bus.rdata[`PMWC_READY_BIT];
                  end
               end else if (q.addr == `PMWC_BYTE_TEST_OFS ||
                            (q.addr == `PMWC_PMT_OFS &&
                             q.wdata[`PMWC_MODE_LSB +: 2] != `PMWC_MODE_D0)) begin
                  d.needRead = 1'b1;
                  d.rdyShadow = 1'b0;
               end
            end
         end
         default: begin
         end
      endcase
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= HOST_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign pready = q.pready;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr;
   assign bus.req = q.req;
   assign bus.we = q.we;
   assign bus.addr = q.addr;
   assign bus.wdata = q.wdata;

endmodule : pmwc_host

// *** pmwc_if.sv ***
// Purpose: Register link between the host controller and the device.
// Assumes: Both ends share core_clk.
// Notes: req is held until ack; ack is a one-cycle pulse with rdata.
`timescale 1ns/10ps
interface pmwc_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic ack;
   logic [31:0] rdata;

   modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : pmwc_if

// *** pmwc_monitor.sv ***
// Purpose: Link and device output checks for the wake control block.
// Assumes: One clock domain, rstn synchronous and active low.
// Notes: Watches the link between the two ends and the device power state, ready and transceiver reset outputs.
`timescale 1ns/10ps
module pmwc_monitor (
   input wire logic core_clk, // Clock.
   input wire logic rstn, // Reset.
   input wire logic req, // Link request.
   input wire logic we, // Link direction.
   input wire logic [7:0] addr, // Link address.
   input wire logic ack, // Link answer.
   input wire logic [31:0] rdata, // Link read data.
   input wire logic phyReset, // Transceiver reset.
   input wire logic [1:0] powerState, // Power state.
   input wire logic deviceReady // Device ready.
);
   localparam int PHY_CYC = 2500;
   logic [11:0] phyCnt_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Counts how long the transceiver reset has been held.
   always_ff @(posedge core_clk) begin
      if (!rstn || !phyReset)
         phyCnt_q <= 12'h000;
      else
         phyCnt_q <= phyCnt_q + 12'h001;
   end
   property p_ack; req && !ack |=> ack; endproperty
   property p_ack_pulse; ack |=> !ack; endproperty
   property p_mode; powerState != 2'h3; endproperty
   property p_sleep; powerState != 2'h0 |-> !deviceReady; endproperty
   property p_rdy; $rose(rstn) |-> (!deviceReady)[*8] ##[6:12] deviceReady; endproperty
   property p_phy_len; $fell(phyReset) |-> phyCnt_q >= PHY_CYC && phyCnt_q <= PHY_CYC + 3;
   endproperty
   property p_phy_src; $rose(phyReset) |-> $past(req && we && addr == 8'h84); endproperty
   property p_wake; ack && we && addr == 8'h64 |-> ##[0:3] powerState == 2'h0; endproperty
   property p_rd; ack && !we && addr == 8'h84 |-> rdata[13:12] == $past(powerState);
   endproperty
   a_ack: assert property (p_ack) else $error("link request not answered");
   a_ack_pulse: assert property (p_ack_pulse) else $error("answer held too long");
   a_mode: assert property (p_mode) else $error("reserved power state");
   a_sleep: assert property (p_sleep) else $error("ready while asleep");
   a_rdy: assert property (p_rdy) else $error("ready delay wrong");
   a_phy_len: assert property (p_phy_len) else $error("transceiver reset length");
   a_phy_src: assert property (p_phy_src) else $error("transceiver reset unasked");
   a_wake: assert property (p_wake) else $error("byte test write did not wake");
   a_rd: assert property (p_rd) else $error("control read wrong state");
   c_phy: cover property (phyReset ##1 !phyReset);
   c_wake: cover property (req && we && addr == 8'h64 && powerState != 2'h0);
   c_rdy: cover property ($rose(deviceReady));
endmodule : pmwc_monitor

// *** pmwc_pkg.sv ***
// Purpose: Types of the wake control block.
// Assumes: Nothing beyond the register header.
// Notes: Each end keeps its whole state in one packed struct.
package pmwc_pkg;

   typedef enum logic [2:0] {
      PMWC_RUN = 3'b001,
      PMWC_SLEEP = 3'b010,
      PMWC_WAKE = 3'b100
   } pmwc_dev_st_t;

   typedef enum logic [2:0] {
      PMWC_H_IDLE = 3'b001,
      PMWC_H_PRE = 3'b010,
      PMWC_H_XFER = 3'b100
   } pmwc_host_st_t;

   typedef struct packed {
      pmwc_dev_st_t st;
      logic [1:0] mode;
      logic wolEn;
      logic edEn;
      logic drvType;
      logic pulseSel;
      logic pol;
      logic outEn;
      logic [1:0] cause;
      logic ready;
      logic readSeen;
      logic phyRst;
      logic [11:0] phyCnt;
      logic actv;
      logic [31:0] pulseCnt;
      logic [7:0] readyCnt;
      logic ack;
      logic [31:0] rdata;
      logic wolS1;
      logic wolS2;
      logic wolS3;
      logic edS1;
      logic edS2;
      logic edS3;
      logic pinO;
      logic pinOe;
      logic irq;
   } pmwc_dev_t;

   typedef struct packed {
      pmwc_host_st_t st;
      logic [7:0] cmdAddr;
      logic cmdWe;
      logic [31:0] cmdWdata;
      logic [31:0] rdata;
      logic refused;
      logic rdyShadow;
      logic needRead;
      logic req;
      logic we;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } pmwc_host_s_t;

endpackage : pmwc_pkg

// *** pmwc_regs.svh ***
// Purpose: Register offsets, bit positions and timing figures of the wake control block.
// Assumes: 25 MHz core clock.
// Notes: Shared by both ends of the register link.
`ifndef PMWC_REGS_SVH
`define PMWC_REGS_SVH

// ------------------------------------------------------------------
// Device register offsets
// ------------------------------------------------------------------
`define PMWC_PMT_OFS 8'h84
`define PMWC_HWCFG_OFS 8'h74
`define PMWC_BYTE_TEST_OFS 8'h64

// ------------------------------------------------------------------
// Power management control fields
// ------------------------------------------------------------------
`define PMWC_MODE_LSB 12
`define PMWC_PHYRST_BIT 10
`define PMWC_WOLEN_BIT 9
`define PMWC_EDEN_BIT 8
`define PMWC_TYPE_BIT 6
`define PMWC_CAUSE_LSB 4
`define PMWC_PULSE_BIT 3
`define PMWC_POL_BIT 2
`define PMWC_OEN_BIT 1
`define PMWC_READY_BIT 0
`define PMWC_MODE_D0 2'h0
`define PMWC_MODE_D1 2'h1
`define PMWC_MODE_D2 2'h2
`define PMWC_MODE_RSVD 2'h3

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define PMWC_CLK_MHZ 25
`define PMWC_PHYRST_US 100
`define PMWC_PULSE_MS 50
`define PMWC_READY_CYC 16

// ------------------------------------------------------------------
// Host controller APB registers
// ------------------------------------------------------------------
`define PMWC_H_CMD_OFS 8'h00
`define PMWC_H_WDATA_OFS 8'h04
`define PMWC_H_STAT_OFS 8'h08
`define PMWC_H_RDATA_OFS 8'h0c
`define PMWC_H_WE_BIT 8
`define PMWC_H_BUSY_BIT 0
`define PMWC_H_REFUSED_BIT 1
`define PMWC_H_RDY_BIT 2
`define PMWC_H_NEEDRD_BIT 3

`endif

// *** power_mgmt_wake_control_tb.sv ***
// Purpose: Self-checking bench for the wake control block with both ends joined.
// Assumes: 25 MHz clock; wake pulse shortened to 20 cycles.
// Notes: Software reaches the device through the host APB registers.
`timescale 1ns/10ps
module power_mgmt_wake_control_tb;
   logic core_clk, rstn, softRst, wolEvent, energyEvent, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, st, cfg, v;
   logic pready, pslverr, phyReset, deviceReady, wakePinO, wakePinOe, wakeIrq, er;
   logic [1:0] powerState, mode, cause;
   int fail_count, samples_checked, n;
   pmwc_if lnk();
   pmwc_device #(.PULSE_CYC(20)) pmwc_device_inst (.core_clk(core_clk), .rstn(rstn),
      .ce(1'b1), .softRst(softRst), .bus(lnk), .wolEvent(wolEvent),
      .energyEvent(energyEvent), .phyReset(phyReset), .powerState(powerState),
      .deviceReady(deviceReady), .wakePinO(wakePinO), .wakePinOe(wakePinOe),
      .wakeIrq(wakeIrq));
   pmwc_host pmwc_host_inst (.core_clk(core_clk), .rstn(rstn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .bus(lnk));
   pmwc_monitor pmwc_monitor_inst (.core_clk(core_clk), .rstn(rstn), .req(lnk.req),
      .we(lnk.we), .addr(lnk.addr), .ack(lnk.ack), .rdata(lnk.rdata),
      .phyReset(phyReset), .powerState(powerState), .deviceReady(deviceReady));
   always #20 core_clk = ~core_clk;
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task dev(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      apb(1'b1, 8'h04, d);
      apb(1'b1, 8'h00, {23'h0, w, a});
      rd = 32'h1;
      while (rd[0] !== 1'b0 && k < 40) begin
         apb(1'b0, 8'h08, 32'h0);
         k++;
      end
      if (k == 40) begin
         fail_count++;
      end
      st = rd;
      apb(1'b0, 8'h0c, 32'h0);
   endtask : dev
   task wr(input logic [31:0] x);
      dev(1'b1, 8'h84, x);
      cfg = x & 32'h34e;
      if (x[13:12] != 2'h3)
         mode = x[13:12];
   endtask : wr
   task wait_rdy;
      int k;
      k = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && k < 30) begin
         dev(1'b0, 8'h84, 32'h0);
         k++;
      end
      if (k == 30) begin
         fail_count++;
      end
   endtask : wait_rdy
   function automatic logic [31:0] pmt(input logic r);
      return cfg | {18'h0, mode, 12'h0} | {26'h0, cause, 4'h0} | {31'h0, r};
   endfunction : pmt
   // Expected {irq, pin enable, pin level} for a given drive type and polarity.
   function automatic logic [31:0] outs(input logic q, input logic a, input logic t,
      input logic p);
      return {29'h0, q, t | a, t & (a ~^ p)};
   endfunction : outs
   function automatic logic [31:0] pins();
      return {29'h0, wakeIrq, wakePinOe, wakePinO};
   endfunction : pins
   initial begin
      #(40 * 60000);
      fail_count++;
      end_sim();
   end
   initial begin
      {core_clk, rstn, softRst, wolEvent, energyEvent, psel, penable, pwrite} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      fail_count = 0;
      samples_checked = 0;
      {cfg, mode, cause} = 36'h0;
      v = $urandom(32'h9e99);
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      wait_rdy();
      chk(rd, pmt(1'b1));
      chk({31'h0, deviceReady}, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, er}, 32'h1);
      wr(32'h400);
      chk({31'h0, phyReset}, 32'h1);
      wr(32'h400);
      dev(1'b0, 8'h84, 32'h0);
      chk(rd, pmt(1'b1) | 32'h400);
      n = 0;
      while (phyReset === 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      dev(1'b0, 8'h84, 32'h0);
      chk(rd, pmt(1'b1));
      wr(32'h246);
      wolEvent <= 1'b1;
      repeat (8 + $urandom % 4) @(posedge core_clk);
      cause = 2'h2;
      chk(pins(), 32'h7);
      wr(32'h266);
      dev(1'b0, 8'h84, 32'h0);
      chk(rd, pmt(1'b1));
      wolEvent <= 1'b0;
      repeat (4) @(posedge core_clk);
      wr(32'h266);
      cause = 2'h0;
      dev(1'b0, 8'h84, 32'h0);
      chk(rd, pmt(1'b1));
      chk(pins(), 32'h2);
      for (int i = 0; i < 3; i++) begin
         v = 32'h10a | {25'h0, i != 2, 3'h0, i != 1, 2'h0};
         wr(v);
         energyEvent <= 1'b1;
         repeat (8 + $urandom % 4) @(posedge core_clk);
         cause = 2'h1;
         chk(pins(), outs(1'b1, 1'b1, v[6], v[2]));
         repeat (30) @(posedge core_clk);
         chk(pins(), outs(1'b1, 1'b0, v[6], v[2]));
         dev(1'b0, 8'h84, 32'h0);
         chk(rd, pmt(1'b1));
         energyEvent <= 1'b0;
         repeat (4) @(posedge core_clk);
         wr(v | 32'h10);
         cause = 2'h0;
         chk(pins(), outs(1'b0, 1'b0, v[6], v[2]));
      end
      wr(32'h300);
      energyEvent <= 1'b1;
      repeat (3) @(posedge core_clk);
      wolEvent <= 1'b1;
      repeat (8) @(posedge core_clk);
      cause = 2'h3;
      chk(pins(), 32'h4);
      dev(1'b0, 8'h84, 32'h0);
      chk(rd, pmt(1'b1));
      {wolEvent, energyEvent} <= 2'b00;
      repeat (4) @(posedge core_clk);
      wr(32'h330);
      cause = 2'h0;
      for (int m = 1; m < 4; m++) begin
         wr({18'h0, m[1:0], 12'h0});
         if (m == 3) begin
            dev(1'b1, 8'h64, $urandom);
            chk(st, 32'h8);
         end
         dev(1'b0, 8'h84, 32'h0);
         chk(rd, pmt(m == 3));
         chk({30'h0, powerState}, {30'h0, mode});
         if (m != 3) begin
            dev(1'b1, 8'h88, 32'h0);
            chk(st, 32'h2);
            dev(1'b0, 8'h80, 32'h0);
            chk(st, 32'h2);
            dev(1'b1, 8'h64, $urandom);
            mode = 2'h0;
            wait_rdy();
            chk(rd, pmt(1'b1));
         end
      end
      wr(32'h246);
      softRst <= 1'b1;
      @(posedge core_clk);
      softRst <= 1'b0;
      cfg = 32'h44;
      wait_rdy();
      chk(rd, pmt(1'b1));
      end_sim();
   end
endmodule : power_mgmt_wake_control_tb
